/* File: logic/asrt_pkg.sv */
package asrt_pkg;
    // word offsets on the register bus
    localparam logic [3:0] ASRT_ADR_DATA   = 4'h0;
    localparam logic [3:0] ASRT_ADR_STATUS = 4'h4;
    localparam logic [3:0] ASRT_ADR_CTRL   = 4'h8;

    // status word bit positions
    localparam int ASRT_ST_PARITY = 0;
    localparam int ASRT_ST_FRAME  = 1;
    localparam int ASRT_ST_OVER   = 2;
    localparam int ASRT_ST_READY  = 3;
    localparam int ASRT_ST_EMPTY  = 4;

    // 16x oversampling counts and the minimum data bits per character
    localparam logic [3:0] ASRT_MID_CNT = 4'h7;
    localparam logic [3:0] ASRT_BIT_CNT = 4'hf;
    localparam logic [3:0] ASRT_MIN_LEN = 4'h5;

    typedef struct packed {
        logic parity_off;
        logic two_stop;
        logic even_par;
        logic len_hi;
        logic len_lo;
    } asrt_ctrl_t;

    typedef struct packed {
        logic tx_empty;
        logic rx_ready;
        logic overrun;
        logic framing;
        logic parity;
    } asrt_stat_t;

    localparam asrt_ctrl_t ASRT_CTRL_RST = 5'h00;
    localparam logic [7:0] ASRT_DATA_RST = 8'h00;

    // data bits per character, 5 to 8
    function automatic logic [3:0] asrt_len(input asrt_ctrl_t c);
        asrt_len = ASRT_MIN_LEN + {2'h0, c.len_hi, c.len_lo};
    endfunction
endpackage

/* File: logic/asrt_edge.sv */
`timescale 1ns/1ns
`default_nettype none
module asrt_edge
    import asrt_pkg::*;
#(
    parameter logic RST_LVL = 1'b1
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic lvl,
    output logic      rise,
    output logic      fall
);
    logic prev_q;

    // previous level, frozen with the clock enable
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prev_q <= RST_LVL;
        end else if (clk_en) begin
            prev_q <= lvl;
        end
    end

    assign rise = clk_en & lvl & ~prev_q;
    assign fall = clk_en & ~lvl & prev_q;
endmodule
`default_nettype wire

/* File: logic/asrt_tx.sv */
`timescale 1ns/1ns
`default_nettype none
module asrt_tx
    import asrt_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    input  wire logic       tick,
    input  wire logic       load,
    input  wire logic [7:0] data,
    input  wire asrt_ctrl_t ctrl,
    output logic            serial,
    output logic            eoc,
    output logic            empty,
    output logic            busy
);
    logic [7:0]  hold_q;
    logic        full_q;
    logic [11:0] shift_q;
    logic [3:0]  rem_q;
    logic [3:0]  cnt_q;
    logic        busy_q;
    logic        ser_q;
    logic        eoc_q;

    // start, data lsb first, optional parity, stop ones fill the rest
    function automatic logic [11:0] frame(input logic [7:0] d,
                                          input asrt_ctrl_t c);
        logic [11:0] f;
        logic [3:0]  n;
        f = 12'hfff;
        n = asrt_len(c);
        f[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(n)) f[i+1] = d[i];
        end
        if (!c.parity_off) f[n+4'h1] = ^d[7:0] ^ ~c.even_par;
        return f;
    endfunction

    wire       start = ~busy_q & full_q;
    wire [3:0] nbits = asrt_len(ctrl) + 4'h2 + {3'h0, ~ctrl.parity_off}
                     + {3'h0, ctrl.two_stop};
    wire [7:0] hmask = 8'hff >> (4'h8 - asrt_len(ctrl));

    // holding register and frame shifter
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hold_q  <= ASRT_DATA_RST;
            full_q  <= 1'b0;
            shift_q <= 12'hfff;
            rem_q   <= 4'h0;
            cnt_q   <= 4'h0;
            busy_q  <= 1'b0;
            ser_q   <= 1'b1;
            eoc_q   <= 1'b1;
        end else if (clk_en) begin
            if (load) begin
                hold_q <= data & hmask;
            end
            full_q <= load | (full_q & ~start);
            if (start) begin
                shift_q <= frame(hold_q, ctrl);
                rem_q   <= nbits;
                cnt_q   <= 4'h0;
                busy_q  <= 1'b1;
                ser_q   <= 1'b0;
                eoc_q   <= 1'b0;
            end else if (busy_q && tick) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == ASRT_BIT_CNT) begin
                    shift_q <= {1'b1, shift_q[11:1]};
                    rem_q   <= rem_q - 4'h1;
                    ser_q   <= shift_q[1];
                    if (rem_q == 4'h1) begin
                        busy_q <= 1'b0;
                        ser_q  <= 1'b1;
                        eoc_q  <= 1'b1;
                    end
                end
            end
        end
    end

    assign serial = ser_q;
    assign eoc    = eoc_q;
    assign empty  = ~full_q;
    assign busy   = busy_q;
endmodule
`default_nettype wire

/* File: logic/asrt_uart.sv */
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module asrt_uart
    import asrt_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ext_reset,
    input  wire logic        rx_clk16,
    input  wire logic        tx_clk16,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             end_of_char,
    input  wire logic        rx_output_enable_n,
    output logic      [7:0]  rx_char_out_o,
    output logic             rx_char_out_oe_n,
    input  wire logic        status_output_enable_n,
    output logic      [4:0]  status_out_o,
    output logic             status_out_oe_n,
    output logic             parity_err_flag,
    output logic             framing_err_flag,
    output logic             overrun_flag,
    output logic             rx_ready_flag,
    output logic             tx_holding_empty,
    input  wire logic        clear_rx_ready_n,
    input  wire logic        tx_data_strobe,
    input  wire logic [7:0]  tx_char_in,
    input  wire logic        ctrl_strobe,
    input  wire logic        parity_off,
    input  wire logic        two_stop_sel,
    input  wire logic        char_len_sel_lo,
    input  wire logic        char_len_sel_hi,
    input  wire logic        even_parity_sel
);
    typedef enum logic [5:0] {
        ASRT_IDLE  = 6'h01,
        ASRT_START = 6'h02,
        ASRT_DATA  = 6'h04,
        ASRT_PAR   = 6'h08,
        ASRT_STOP1 = 6'h10,
        ASRT_STOP2 = 6'h20
    } asrt_rx_st_t;

    asrt_rx_st_t st_q;
    asrt_ctrl_t  ctrl_q;
    logic [3:0]  cnt_q;
    logic [2:0]  bit_q;
    logic [7:0]  sh_q;
    logic        par_q;
    logic        fe_q;
    logic [7:0]  hold_q;
    logic        pe_q;
    logic        fr_q;
    logic        or_q;
    logic        rdy_q;
    logic        ack_q;
    logic [31:0] dat_q;
    logic        xfer;
    logic        rx_tick;
    logic        tx_tick;
    logic        si_fall;
    logic        ds_rise;
    logic        tx_busy;
    logic        tx_empty;

    // external reset acts like the system reset on every register except the bus ack and read data
    wire rst = sys_rst | ext_reset;

    // register bus decode
    wire        req      = wb_cyc_i & wb_stb_i;
    wire        bus_wr   = clk_en & req & ack_q & wb_we_i & wb_sel_i[0];
    wire        bus_rd   = clk_en & req & ack_q & ~wb_we_i;
    wire        hit_data = wb_adr_i == ASRT_ADR_DATA;
    wire        hit_stat = wb_adr_i == ASRT_ADR_STATUS;
    wire        hit_ctrl = wb_adr_i == ASRT_ADR_CTRL;
    wire        wr_data  = bus_wr & hit_data;
    wire        wr_ctrl  = bus_wr & hit_ctrl;
    wire        rd_data  = bus_rd & hit_data;
    asrt_stat_t stat;
    assign stat = '{tx_empty, rdy_q, or_q, fr_q, pe_q};

    // read mux; unmapped offsets read as zero
    wire [31:0] rd_mux = hit_data ? {24'h0, hold_q}
                       : hit_stat ? {27'h0, stat}
                       : hit_ctrl ? {27'h0, ctrl_q}
                       : 32'h0;

    // pin control inputs plus a bus write path into the same register
    asrt_ctrl_t ctrl_pins;
    assign ctrl_pins = '{parity_off, two_stop_sel, even_parity_sel,
                         char_len_sel_hi, char_len_sel_lo};

    // edge detectors: the 16x clocks are sampled, falls give bit ticks
    asrt_edge #(.RST_LVL(1'b0)) u_rxclk (
        .sys_clk (sys_clk),
        .sys_rst (rst),
        .clk_en  (clk_en),
        .lvl     (rx_clk16),
        .rise    (),
        .fall    (rx_tick)
    );
    asrt_edge #(.RST_LVL(1'b0)) u_txclk (
        .sys_clk (sys_clk),
        .sys_rst (rst),
        .clk_en  (clk_en),
        .lvl     (tx_clk16),
        .rise    (),
        .fall    (tx_tick)
    );
    asrt_edge #(.RST_LVL(1'b1)) u_si (
        .sys_clk (sys_clk),
        .sys_rst (rst),
        .clk_en  (clk_en),
        .lvl     (serial_in),
        .rise    (),
        .fall    (si_fall)
    );
    asrt_edge #(.RST_LVL(1'b0)) u_ds (
        .sys_clk (sys_clk),
        .sys_rst (rst),
        .clk_en  (clk_en),
        .lvl     (tx_data_strobe),
        .rise    (ds_rise),
        .fall    ()
    );

    // transmitter; a bus write to the data word acts as a strobe
    asrt_tx u_tx (
        .sys_clk (sys_clk),
        .sys_rst (rst),
        .clk_en  (clk_en),
        .tick    (tx_tick),
        .load    (ds_rise | wr_data),
        .data    (wr_data ? wb_dat_i[7:0] : tx_char_in),
        .ctrl    (ctrl_q),
        .serial  (serial_out),
        .eoc     (end_of_char),
        .empty   (tx_empty),
        .busy    (tx_busy)
    );

    // wishbone: ack one cycle after the request, dropped the next
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else if (clk_en) begin
            ack_q <= req & ~ack_q;
            dat_q <= rd_mux;
        end
    end

    // control holding register; the strobe may be tied high
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= ASRT_CTRL_RST;
        end else if (clk_en) begin
            if (ctrl_strobe) begin
                ctrl_q <= ctrl_pins;
            end else if (wr_ctrl) begin
                ctrl_q <= wb_dat_i[4:0];
            end
        end
    end

    wire [3:0] len      = asrt_len(ctrl_q);
    wire       mid      = rx_tick & (cnt_q == ASRT_MID_CNT);
    wire       cell_end = rx_tick & (cnt_q == ASRT_BIT_CNT);
    wire       last_bit = {1'b0, bit_q} == len - 4'h1;
    // hold window ends at the falling edge of the 16x clock, so a start
    // edge seen while the clock is high waits for that edge to count
    wire       stop_ok  = serial_in;

    // receive state machine, counting 16x falls from the start edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q  <= ASRT_IDLE;
            cnt_q <= 4'h0;
            bit_q <= 3'h0;
            sh_q  <= 8'h00;
            par_q <= 1'b0;
            fe_q  <= 1'b0;
        end else if (clk_en) begin
            if (rx_tick) begin
                cnt_q <= cnt_q + 4'h1;
            end
            case (st_q)
                ASRT_IDLE: begin
                    if (si_fall) begin
                        st_q  <= ASRT_START;
                        cnt_q <= 4'h0;
                        sh_q  <= 8'h00;
                        bit_q <= 3'h0;
                        fe_q  <= 1'b0;
                    end
                end
                ASRT_START: begin
                    if (mid) begin
                        cnt_q <= 4'h0;
                        st_q  <= serial_in ? ASRT_IDLE : ASRT_DATA;
                    end
                end
                ASRT_DATA: begin
                    if (cell_end) begin
                        sh_q[bit_q] <= serial_in;
                        bit_q <= bit_q + 3'h1;
                        if (last_bit) begin
                            st_q <= ctrl_q.parity_off ? ASRT_STOP1
                                                      : ASRT_PAR;
                        end
                    end
                end
                ASRT_PAR: begin
                    if (cell_end) begin
                        par_q <= serial_in;
                        st_q  <= ASRT_STOP1;
                    end
                end
                ASRT_STOP1: begin
                    if (cell_end) begin
                        fe_q <= ~stop_ok;
                        st_q <= ctrl_q.two_stop ? ASRT_STOP2
                                                : ASRT_IDLE;
                    end
                end
                ASRT_STOP2: begin
                    if (cell_end) begin
                        fe_q <= fe_q | ~stop_ok;
                        st_q <= ASRT_IDLE;
                    end
                end
                default: st_q <= ASRT_IDLE;
            endcase
        end
    end

    // character complete at the end of its last stop cell
    assign xfer = clk_en & cell_end
                & ((st_q == ASRT_STOP1 & ~ctrl_q.two_stop)
                 | st_q == ASRT_STOP2);
    wire fe_now  = fe_q & (st_q == ASRT_STOP2) | ~stop_ok;
    wire pe_now  = ~ctrl_q.parity_off
                 & ~(^sh_q ^ par_q ^ ctrl_q.even_par);
    wire clr_rdy = clk_en & (~clear_rx_ready_n | rd_data);

    // holding registers; a new character wins over a same-cycle clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hold_q <= ASRT_DATA_RST;
            pe_q   <= 1'b0;
            fr_q   <= 1'b0;
            or_q   <= 1'b0;
            rdy_q  <= 1'b0;
        end else if (xfer) begin
            hold_q <= sh_q;
            pe_q   <= pe_now;
            fr_q   <= fe_now;
            or_q   <= rdy_q;
            rdy_q  <= 1'b1;
        end else if (clr_rdy) begin
            rdy_q  <= 1'b0;
        end
    end

    // pin-side outputs; drivers enabled while the enables are low
    assign rx_char_out_o    = hold_q;
    assign rx_char_out_oe_n = rx_output_enable_n;
    assign status_out_o     = stat;
    assign status_out_oe_n  = status_output_enable_n;
    assign parity_err_flag  = pe_q;
    assign framing_err_flag = fr_q;
    assign overrun_flag     = or_q;
    assign rx_ready_flag    = rdy_q;
    assign tx_holding_empty = tx_empty;
    assign wb_dat_o         = dat_q;
    assign wb_ack_o         = ack_q;

    // checks
    sequence s_overrun_char;
        xfer && rdy_q;
    endsequence

    property p_ready_set;
        @(posedge sys_clk) disable iff (rst)
        xfer |=> rdy_q && hold_q == $past(sh_q);
    endproperty
    a_ready_set: assert property (p_ready_set)
        else $error("ready not set after transfer");

    property p_overrun;
        @(posedge sys_clk) disable iff (rst)
        s_overrun_char |=> or_q;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun flag missed");

    property p_clear_ready;
        @(posedge sys_clk) disable iff (rst)
        clk_en && !clear_rx_ready_n && !xfer |=> !rdy_q;
    endproperty
    a_clear_ready: assert property (p_clear_ready)
        else $error("ready not cleared");

    property p_no_parity;
        @(posedge sys_clk) disable iff (rst)
        xfer && ctrl_q.parity_off |=> !pe_q;
    endproperty
    a_no_parity: assert property (p_no_parity)
        else $error("parity error with parity off");

    property p_start_reject;
        @(posedge sys_clk) disable iff (rst)
        clk_en && st_q == ASRT_START && mid && serial_in
        |=> st_q == ASRT_IDLE;
    endproperty
    a_start_reject: assert property (p_start_reject)
        else $error("false start not rejected");

    property p_ext_reset;
        @(posedge sys_clk) disable iff (sys_rst)
        ext_reset |=> serial_out && end_of_char && tx_holding_empty
                      && !rdy_q;
    endproperty
    a_ext_reset: assert property (p_ext_reset)
        else $error("reset values wrong");

    property p_ctrl_load;
        @(posedge sys_clk) disable iff (rst)
        clk_en && ctrl_strobe |=> ctrl_q == $past(ctrl_pins);
    endproperty
    a_ctrl_load: assert property (p_ctrl_load)
        else $error("control bits not loaded");

    property p_tx_idle;
        @(posedge sys_clk) disable iff (rst)
        !tx_busy |-> serial_out && end_of_char;
    endproperty
    a_tx_idle: assert property (p_tx_idle)
        else $error("serial output not marking when idle");

    property p_load_empty;
        @(posedge sys_clk) disable iff (rst)
        ds_rise && !tx_busy |=> !tx_holding_empty ##1 tx_busy;
    endproperty
    a_load_empty: assert property (p_load_empty)
        else $error("strobe did not load and start");
endmodule
`default_nettype wire

/* File: dv/asrt_term.sv */
`timescale 1ns/1ns
`default_nettype none
module asrt_term
    import asrt_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        rx_clk16,
    input  wire logic        tx_clk16,
    input  wire logic        go,
    input  wire logic [11:0] frame,
    input  wire logic [3:0]  nbits,
    input  wire logic        line_in,
    output logic             line_out,
    output logic             busy,
    output logic      [11:0] cap
);
    logic        rxc_q, txc_q, run_q;
    logic [11:0] sh_q;
    logic [3:0]  scnt_q, ssub_q, ccnt_q, csub_q;
    wire         rx_tick = rxc_q & ~rx_clk16;
    wire         tx_tick = txc_q & ~tx_clk16;
    // the line marks between frames, so only a real start can fall
    assign line_out = (scnt_q != 4'h0) ? sh_q[0] : 1'b1;
    assign busy = (scnt_q != 4'h0) | (ccnt_q != 4'h0);
    // sender: lsb first, one cell per 16 receiver ticks; capture on tx
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rxc_q <= 1'b0;
            txc_q <= 1'b0;
            run_q <= 1'b0;
            sh_q <= 12'hfff;
            scnt_q <= 4'h0;
            ssub_q <= 4'h0;
            ccnt_q <= 4'h0;
            csub_q <= 4'h0;
            cap <= 12'h000;
        end else begin
            rxc_q <= rx_clk16;
            txc_q <= tx_clk16;
            if (go) begin
                sh_q <= frame;
                scnt_q <= nbits;
                ssub_q <= 4'h0;
                ccnt_q <= nbits;
                run_q <= 1'b0;
            end else begin
                if (scnt_q != 4'h0 && rx_tick) begin
                    ssub_q <= ssub_q + 4'h1;
                    if (ssub_q == 4'hf) begin
                        sh_q <= sh_q >> 1;
                        scnt_q <= scnt_q - 4'h1;
                    end
                end
                // wait for the start edge, then sample each mid cell
                if (ccnt_q != 4'h0 && tx_tick) begin
                    csub_q <= csub_q + 4'h1;
                    if (!run_q) begin
                        run_q <= ~line_in;
                        csub_q <= 4'h1;
                    end else if (csub_q == 4'h7) begin
                        cap <= {line_in, cap[11:1]};
                        ccnt_q <= ccnt_q - 4'h1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/tb_asrt_uart.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_asrt_uart
    import asrt_pkg::*;
;
    logic        sys_clk, sys_rst, clk_en, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [3:0]  wb_adr_i, wb_sel_i, nbits;
    logic [31:0] wb_dat_i, wb_dat_o, rnd, q;
    logic        wb_ack_o, ext_reset, rx_clk16, tx_clk16, serial_in;
    logic        serial_out, end_of_char, rx_output_enable_n, glitch;
    logic [7:0]  rx_char_out_o, tx_char_in;
    logic        rx_char_out_oe_n, status_output_enable_n, status_out_oe_n;
    logic [4:0]  status_out_o;
    logic        parity_err_flag, framing_err_flag, overrun_flag;
    logic        rx_ready_flag, tx_holding_empty, clear_rx_ready_n;
    logic        tx_data_strobe, ctrl_strobe, parity_off, two_stop_sel;
    logic        char_len_sel_lo, char_len_sel_hi, even_parity_sel;
    logic        go, term_busy, term_line;
    logic [11:0] frame, cap;
    logic [2:0]  div_q;
    asrt_ctrl_t  c;
    int          err_total, num_checks;

    asrt_uart u_dut (.sys_clk, .sys_rst, .clk_en, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .ext_reset, .rx_clk16, .tx_clk16, .serial_in, .serial_out,
        .end_of_char, .rx_output_enable_n, .rx_char_out_o,
        .rx_char_out_oe_n, .status_output_enable_n, .status_out_o,
        .status_out_oe_n, .parity_err_flag, .framing_err_flag,
        .overrun_flag, .rx_ready_flag, .tx_holding_empty,
        .clear_rx_ready_n, .tx_data_strobe, .tx_char_in, .ctrl_strobe,
        .parity_off, .two_stop_sel, .char_len_sel_lo, .char_len_sel_hi,
        .even_parity_sel);
    asrt_term u_term (.sys_clk, .sys_rst, .rx_clk16, .tx_clk16, .go,
        .frame, .nbits, .line_in(serial_out), .line_out(term_line),
        .busy(term_busy), .cap);

    // a short low glitch is laid over the line to fake a false start
    assign serial_in = term_line & ~glitch;

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // 16x clocks: receiver ticks every 4 cycles, transmitter every 8
    always @(posedge sys_clk) begin
        div_q <= div_q + 3'h1;
        rx_clk16 <= div_q[1];
        tx_clk16 <= div_q[2];
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // returns {cell count, frame lsb first, stop cells set}
    function automatic logic [15:0] mk(input asrt_ctrl_t k, logic [7:0] d);
        logic [3:0]  n;
        logic [11:0] f;
        n = 4'h5 + {2'h0, k.len_hi, k.len_lo};
        f = {3'h7, d & (8'hff >> (4'h8 - n)), 1'b0} | (12'hfff << (n + 1));
        if (!k.parity_off)
            f[n + 1] = ^(d & (8'hff >> (4'h8 - n))) ^ ~k.even_par;
        return {n + 4'h2 + {3'h0, ~k.parity_off} + {3'h0, k.two_stop}, f};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic hang(input int k, input int lim);
        if (k >= lim) begin
            err_total++;
            results();
        end
    endtask
    // classic single cycle: hold until ack, take data at that edge
    task automatic wb(input logic w, logic [3:0] a, logic [31:0] d);
        int k;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (wb_ack_o === 1'b1)
                break;
        end
        hang(k, 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // r: tx char, rx char, fault kind; way 0 pin clear, 1 read, 2 none
    task automatic run(input logic [31:0] r, int way, logic ov);
        logic [15:0] ft, fr;
        logic [11:0] f;
        logic [3:0]  n;
        logic        pe, fe;
        int          k;
        ft = mk(c, r[7:0]);
        fr = mk(c, r[15:8]);
        n = 4'h5 + {2'h0, c.len_hi, c.len_lo};
        f = fr[11:0];
        pe = r[17:16] == 2'h1 && !c.parity_off;
        fe = r[17:16] == 2'h2;
        f[n + 1] = f[n + 1] ^ pe;
        if (fe)
            f[n + 1 + {3'h0, ~c.parity_off}] = 1'b0;
        @(posedge sys_clk);
        tx_char_in <= r[7:0];
        tx_data_strobe <= 1'b1;
        frame <= f;
        nbits <= fr[15:12];
        go <= 1'b1;
        rx_output_enable_n <= r[18];
        status_output_enable_n <= r[19];
        @(posedge sys_clk);
        tx_data_strobe <= 1'b0;
        go <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk({end_of_char, tx_holding_empty}, 2'h1);
        for (k = 0; k < 3000 && (term_busy || !end_of_char); k++)
            @(posedge sys_clk);
        hang(k, 3000);
        chk(cap >> (4'hc - ft[15:12]),
            ft[11:0] & (12'hfff >> (4'hc - ft[15:12])));
        chk(serial_out, 1'b1);
        chk(rx_char_out_o, r[15:8] & (8'hff >> (4'h8 - n)));
        chk({parity_err_flag, framing_err_flag}, {pe, fe});
        chk(status_out_o, {1'b1, 1'b1, ov, fe, pe});
        chk(overrun_flag, ov);
        chk({status_out_oe_n, rx_char_out_oe_n}, r[19:18]);
        if (way == 1) begin
            wb(1'b0, ASRT_ADR_DATA, 32'h0);
            chk(q, {24'h0, r[15:8] & (8'hff >> (4'h8 - n))});
        end else if (way == 0) begin
            @(posedge sys_clk);
            clear_rx_ready_n <= 1'b0;
            @(posedge sys_clk);
            clear_rx_ready_n <= 1'b1;
        end
        @(posedge sys_clk);
        chk(rx_ready_flag, way == 2);
    endtask
    task automatic set_ctrl;
        @(posedge sys_clk);
        {parity_off, two_stop_sel, even_parity_sel, char_len_sel_hi,
            char_len_sel_lo} <= c;
        ctrl_strobe <= 1'b1;
        @(posedge sys_clk);
        ctrl_strobe <= 1'b0;
    endtask

    initial begin
        {sys_rst, clk_en, wb_sel_i, rnd} = {6'h3f, 32'hcad41215};
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 39'h0;
        {ext_reset, glitch, go, tx_data_strobe, ctrl_strobe} = 5'h0;
        {clear_rx_ready_n, rx_output_enable_n, status_output_enable_n} = 3'h7;
        {tx_char_in, frame, nbits, div_q, c} = 32'h0;
        {parity_off, two_stop_sel, even_parity_sel} = 3'h0;
        {char_len_sel_hi, char_len_sel_lo, err_total, num_checks} = 66'h0;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        chk({serial_out, end_of_char, tx_holding_empty, rx_ready_flag},
            4'he);
        wb(1'b1, ASRT_ADR_CTRL, 32'h1b);
        wb(1'b0, ASRT_ADR_CTRL, 32'h0);
        chk(q, 32'h1b);
        wb(1'b0, 4'hc, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, ASRT_ADR_STATUS, 32'h0);
        chk(q, 32'h10);
        // every length, both parities, parity off, faults among them
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            c = {i == 3 || i == 6, rnd[20], i[2], i[1], i[0]};
            set_ctrl();
            if (i < 2)
                rnd[17:16] = i[1:0] + 2'h1;
            run(rnd, i % 2, 1'b0);
        end
        // second character lands while the first is unread
        c = 5'h03;
        set_ctrl();
        run(lfsr(rnd) & 32'hfcffff, 2, 1'b0);
        run(lfsr(lfsr(rnd)) & 32'hfcffff, 0, 1'b1);
        // a low pulse of two ticks must not pass for a start bit
        @(posedge sys_clk);
        glitch <= 1'b1;
        repeat (8) @(posedge sys_clk);
        glitch <= 1'b0;
        repeat (1000) @(posedge sys_clk);
        chk(rx_ready_flag, 1'b0);
        // external reset in mid character; a data word write sends it
        wb(1'b1, ASRT_ADR_DATA, 32'ha5);
        repeat (100) @(posedge sys_clk);
        chk(end_of_char, 1'b0);
        ext_reset <= 1'b1;
        @(posedge sys_clk);
        ext_reset <= 1'b0;
        @(posedge sys_clk);
        chk({serial_out, end_of_char, tx_holding_empty, rx_ready_flag},
            4'he);
        results();
    end
endmodule
`default_nettype wire
